/* File: design/dds_core.sv */
// Synthesizer core with sample-clock divider, prescalers and driver source control.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A 48-bit phase accumulator adds the tuning word every sample clock on which the FIFO is not full.
// - Output frequency is tuning word times sample rate over 2^48.
// - The phase offset word is added to every accumulator phase sample.
// - Offset phase maps to amplitude through a cosine of one revolution.
// - One amplitude per accumulator step goes through the FIFO to the 10-bit converter input.
// - Sample-clock divider ratio is 1, 2, 4 or 8, set by control.
// - Synthesizer clock is divided or undivided input; driver may take the other.
// - Reference and feedback prescalers each divide by 1 through 16.
// - A three-bit field scales pump base current by 1 to 8.
// - Driver source is undivided input, divided input or feedback input.
// - Controls add rising and falling surge current or disable the default surge.
// - A control bit switches in the internal driver current resistor.
// - A control engages the crystal oscillator on the reference input.
// - Eight profiles hold tuning and phase words, chosen by three select pins.
// - Holding values move to active on a sync clock edge with update high.
// - The sync clock is the sample clock divided by four.
// - Active-high master reset clears accumulators and restores default configuration.
module dds_core
  import dds_pkg::*;
(
  // Clock and resets
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                masterReset,
  // Profile holding writes
  input  wire logic                profWrEn,
  input  wire logic [PSEL_W-1:0]   profWrAddr,
  input  wire logic [ACC_W-1:0]    profWrTuning,
  input  wire logic [PHASE_W-1:0]  profWrPhase,
  // Control holding values
  input  wire rfDiv_t              cfgRfDiv,
  input  wire logic                cfgSynthUndiv,
  input  wire logic [PRESC_W-1:0]  cfgRefPresc,
  input  wire logic [PRESC_W-1:0]  cfgFbPresc,
  input  wire logic [PUMP_W-1:0]   cfgPumpScale,
  input  wire drvSrc_t             cfgDrvSrc,
  input  wire logic                cfgSurgeRise,
  input  wire logic                cfgSurgeFall,
  input  wire logic                cfgSurgeDefaultOff,
  input  wire logic                cfgIntRes,
  input  wire logic                cfgXtalOsc,
  // Pins
  input  wire logic                updateStrobe,
  input  wire logic [PSEL_W-1:0]   profileSelect,
  input  wire logic                referenceInput,
  input  wire logic                feedbackInput,
  // Converter
  output logic      [DAC_W-1:0]    dacData,
  output logic                     dacValid,
  input  wire logic                dacReady,
  // Clock outputs
  output logic                     syncOut,
  output logic                     driverOut,
  output logic                     refDivPulse,
  output logic                     fbDivPulse,
  // Active configuration
  output rfDiv_t                   rfDivSel,
  output logic                     synthUndiv,
  output logic      [PUMP_W-1:0]   pumpScale,
  output logic      [PUMP_W:0]     pumpMult,
  output drvSrc_t                  drvSrc,
  output logic                     surgeRiseEn,
  output logic                     surgeFallEn,
  output logic                     surgeDefaultOff,
  output logic                     intResEn,
  output logic                     xtalOscEn
);

  // ---------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0]        rstSync_reg;
  logic              rstN;
  logic [1:0]        mrstSync_reg;
  logic [1:0]        updSync_reg;
  logic [PSEL_W-1:0] selSync1_reg;
  logic [PSEL_W-1:0] selSync2_reg;
  logic [PSEL_W-1:0] selSync3_reg;
  logic [PSEL_W-1:0] selUse_reg;
  logic              clr;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_reg <= 2'h0;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstN = rstSync_reg[1];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mrstSync_reg <= 2'h0;
      updSync_reg  <= 2'h0;
      selSync1_reg <= '0;
      selSync2_reg <= '0;
      selSync3_reg <= '0;
      selUse_reg   <= '0;
    end else begin
      mrstSync_reg <= {mrstSync_reg[0], masterReset};
      updSync_reg  <= {updSync_reg[0], updateStrobe};
      selSync1_reg <= profileSelect;
      selSync2_reg <= selSync1_reg;
      selSync3_reg <= selSync2_reg;
      // The select pins move as a word; taking it only once it has held still keeps skewed bits from picking a stray profile.
      if (selSync2_reg == selSync3_reg) begin
        selUse_reg <= selSync2_reg;
      end
    end
  end
  assign clr = mrstSync_reg[1];

  // ---------------------------------------------------------------------------
  // Sample-clock divider and sync clock
  // ---------------------------------------------------------------------------
  logic [RFCNT_W-1:0] divCnt_reg;
  logic [RFCNT_W-1:0] divMask;
  logic               divTick;
  logic               divLevel;
  logic               sampleTick;
  logic [1:0]         syncCnt_reg;
  logic               syncEdge;
  logic               loadActive;

  always_comb begin
    unique case (rfDivSel)
      RF_DIV1: divMask = 3'h0;
      RF_DIV2: divMask = 3'h1;
      RF_DIV4: divMask = 3'h3;
      RF_DIV8: divMask = 3'h7;
    endcase
  end

  // Ratio 1 has no slower edge to show, so the level toggles each cycle.
  always_comb begin
    unique case (rfDivSel)
      RF_DIV1: divLevel = divCnt_reg[0];
      RF_DIV2: divLevel = divCnt_reg[0];
      RF_DIV4: divLevel = divCnt_reg[1];
      RF_DIV8: divLevel = divCnt_reg[2];
    endcase
  end

  assign divTick    = ((divCnt_reg & divMask) == divMask);
  assign sampleTick = synthUndiv ? 1'b1 : divTick;
  assign syncEdge   = sampleTick && (syncCnt_reg == SYNC_LAST);
  assign loadActive = syncEdge && updSync_reg[1];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      divCnt_reg  <= '0;
      syncCnt_reg <= 2'h0;
      syncOut     <= 1'b0;
    end else if (clr) begin
      divCnt_reg  <= '0;
      syncCnt_reg <= 2'h0;
      syncOut     <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_reg + 1'b1;
      if (sampleTick) begin
        syncCnt_reg <= syncCnt_reg + 1'b1;
      end
      syncOut <= syncCnt_reg[1];
    end
  end

  // ---------------------------------------------------------------------------
  // Profiles: holding and active copies
  // ---------------------------------------------------------------------------
  logic [ACC_W-1:0]   holdTuning_reg [PROFILES];
  logic [PHASE_W-1:0] holdPhase_reg  [PROFILES];
  logic [ACC_W-1:0]   actTuning_reg  [PROFILES];
  logic [PHASE_W-1:0] actPhase_reg   [PROFILES];
  logic [ACC_W-1:0]   curTuning;
  logic [PHASE_W-1:0] curPhase;

  for (genvar p = 0; p < PROFILES; p++) begin : g_prof
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        holdTuning_reg[p] <= TUNING_RST;
        holdPhase_reg[p]  <= PHASE_RST;
        actTuning_reg[p]  <= TUNING_RST;
        actPhase_reg[p]   <= PHASE_RST;
      end else if (clr) begin
        holdTuning_reg[p] <= TUNING_RST;
        holdPhase_reg[p]  <= PHASE_RST;
        actTuning_reg[p]  <= TUNING_RST;
        actPhase_reg[p]   <= PHASE_RST;
      end else begin
        if (profWrEn && (profWrAddr == PSEL_W'(p))) begin
          holdTuning_reg[p] <= profWrTuning;
          holdPhase_reg[p]  <= profWrPhase;
        end
        if (loadActive) begin
          actTuning_reg[p] <= holdTuning_reg[p];
          actPhase_reg[p]  <= holdPhase_reg[p];
        end
      end
    end
  end

  // Tuning and phase always come from the same profile.
  assign curTuning = actTuning_reg[selUse_reg];
  assign curPhase  = actPhase_reg[selUse_reg];

  // ---------------------------------------------------------------------------
  // Active control register
  // ---------------------------------------------------------------------------
  logic [PRESC_W-1:0] refPresc_reg;
  logic [PRESC_W-1:0] fbPresc_reg;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rfDivSel        <= RF_DIV_RST;
      synthUndiv      <= 1'b0;
      refPresc_reg    <= PRESC_RST;
      fbPresc_reg     <= PRESC_RST;
      pumpScale       <= PUMP_RST;
      pumpMult        <= PUMP_ONE;
      drvSrc          <= DRV_SRC_RST;
      surgeRiseEn     <= 1'b0;
      surgeFallEn     <= 1'b0;
      surgeDefaultOff <= 1'b0;
      intResEn        <= 1'b0;
      xtalOscEn       <= 1'b0;
    end else if (clr) begin
      rfDivSel        <= RF_DIV_RST;
      synthUndiv      <= 1'b0;
      refPresc_reg    <= PRESC_RST;
      fbPresc_reg     <= PRESC_RST;
      pumpScale       <= PUMP_RST;
      pumpMult        <= PUMP_ONE;
      drvSrc          <= DRV_SRC_RST;
      surgeRiseEn     <= 1'b0;
      surgeFallEn     <= 1'b0;
      surgeDefaultOff <= 1'b0;
      intResEn        <= 1'b0;
      xtalOscEn       <= 1'b0;
    end else if (loadActive) begin
      rfDivSel        <= cfgRfDiv;
      synthUndiv      <= cfgSynthUndiv;
      refPresc_reg    <= cfgRefPresc;
      fbPresc_reg     <= cfgFbPresc;
      pumpScale       <= cfgPumpScale;
      pumpMult        <= {1'b0, cfgPumpScale} + PUMP_ONE;
      drvSrc          <= cfgDrvSrc;
      surgeRiseEn     <= cfgSurgeRise;
      surgeFallEn     <= cfgSurgeFall;
      surgeDefaultOff <= cfgSurgeDefaultOff;
      intResEn        <= cfgIntRes;
      xtalOscEn       <= cfgXtalOsc;
    end
  end

  // ---------------------------------------------------------------------------
  // Reference and feedback prescalers
  // ---------------------------------------------------------------------------
  logic [1:0]         pinIn;
  logic [1:0]         pinS1_reg;
  logic [1:0]         pinS2_reg;
  logic [1:0]         pinS3_reg;
  logic [1:0]         pinEdge;
  logic [PRESC_W-1:0] prescCnt_reg [2];
  logic [PRESC_W-1:0] prescDiv     [2];
  logic [1:0]         prescOut_reg;

  assign pinIn       = {feedbackInput, referenceInput};
  assign prescDiv[0] = refPresc_reg;
  assign prescDiv[1] = fbPresc_reg;
  assign refDivPulse = prescOut_reg[0];
  assign fbDivPulse  = prescOut_reg[1];

  for (genvar c = 0; c < 2; c++) begin : g_presc
    assign pinEdge[c] = pinS2_reg[c] && !pinS3_reg[c];
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        pinS1_reg[c]    <= 1'b0;
        pinS2_reg[c]    <= 1'b0;
        pinS3_reg[c]    <= 1'b0;
        prescCnt_reg[c] <= '0;
        prescOut_reg[c] <= 1'b0;
      end else begin
        pinS1_reg[c]    <= pinIn[c];
        pinS2_reg[c]    <= pinS1_reg[c];
        pinS3_reg[c]    <= pinS2_reg[c];
        prescOut_reg[c] <= 1'b0;
        if (clr) begin
          prescCnt_reg[c] <= '0;
        end else if (pinEdge[c]) begin
          // A field value of v gives one pulse every v+1 input edges.
          if (prescCnt_reg[c] >= prescDiv[c]) begin
            prescCnt_reg[c] <= '0;
            prescOut_reg[c] <= 1'b1;
          end else begin
            prescCnt_reg[c] <= prescCnt_reg[c] + 1'b1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Output driver source
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      driverOut <= 1'b0;
    end else begin
      unique case (drvSrc)
        DRV_UNDIV:    driverOut <= divCnt_reg[0];
        DRV_DIV:      driverOut <= divLevel;
        DRV_FEEDBACK: driverOut <= pinS2_reg[1];
        default:      driverOut <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Phase accumulator, offset and amplitude path
  // ---------------------------------------------------------------------------
  logic [ACC_W-1:0]   phaseAcc_reg;
  logic [PHASE_W-1:0] offsetPhase;
  logic [DAC_W-1:0]   ampWord;
  logic               fifoInReady;
  logic               advance;
  logic               fifoOutValid;
  logic [DAC_W-1:0]   fifoOutData;
  logic               fifoPop;

  // Full FIFO stalls the accumulator so no sample is lost to a slow converter.
  assign advance     = sampleTick && fifoInReady && !clr;
  assign offsetPhase = phaseAcc_reg[ACC_W-1 -: PHASE_W] + curPhase;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      phaseAcc_reg <= '0;
    end else if (clr) begin
      phaseAcc_reg <= '0;
    end else if (advance) begin
      phaseAcc_reg <= phaseAcc_reg + curTuning;
    end
  end

  dds_cos_lut #(
    .PHASE_W (LUT_W),
    .AMP_W   (DAC_W)
  ) u_cos (
    .phase (offsetPhase[PHASE_W-1 -: LUT_W]),
    .amp   (ampWord)
  );

  dds_fifo #(
    .WIDTH (DAC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (advance),
    .inReady  (fifoInReady),
    .inData   (ampWord),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  assign fifoPop = fifoOutValid && (!dacValid || dacReady);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dacValid <= 1'b0;
      dacData  <= '0;
    end else if (fifoPop) begin
      dacValid <= 1'b1;
      dacData  <= fifoOutData;
    end else if (dacReady) begin
      dacValid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN);

  property p_accStep;
    advance |=> phaseAcc_reg == ACC_W'($past(phaseAcc_reg) + $past(curTuning));
  endproperty
  a_accStep: assert property (p_accStep) else $error("accumulator step wrong");

  property p_accHold;
    !advance && !clr |=> $stable(phaseAcc_reg);
  endproperty
  a_accHold: assert property (p_accHold) else $error("accumulator moved without tick");

  property p_div4;
    sampleTick && rfDivSel == RF_DIV4 && !synthUndiv && !loadActive && !clr |=> !sampleTick [*3] ##1 sampleTick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four spacing wrong");

  property p_loadTakes;
    loadActive && !clr |=> rfDivSel == $past(cfgRfDiv) && drvSrc == $past(cfgDrvSrc);
  endproperty
  a_loadTakes: assert property (p_loadTakes) else $error("update did not load");

  property p_noLoad;
    !loadActive && !clr |=> $stable(rfDivSel) && $stable(pumpScale);
  endproperty
  a_noLoad: assert property (p_noLoad) else $error("config changed without update");

  property p_pumpMult;
    pumpMult == {1'b0, pumpScale} + PUMP_ONE;
  endproperty
  a_pumpMult: assert property (p_pumpMult) else $error("pump multiplier mismatch");

  property p_dacHold;
    dacValid && !dacReady |=> dacValid && $stable(dacData);
  endproperty
  a_dacHold: assert property (p_dacHold) else $error("converter word dropped");

  property p_drvFb;
    drvSrc == DRV_FEEDBACK |=> driverOut == $past(pinS2_reg[1]);
  endproperty
  a_drvFb: assert property (p_drvFb) else $error("driver not following feedback");

  property p_mreset;
    clr |=> phaseAcc_reg == '0 && rfDivSel == RF_DIV_RST;
  endproperty
  a_mreset: assert property (p_mreset) else $error("master reset did not clear");

  // At full rate the sync edge recurs every fourth sample; a master reset restarts the count.
  property p_syncQuarter;
    disable iff (!rstN || clr)
    syncEdge && synthUndiv && !loadActive |=> !syncEdge [*3] ##1 syncEdge;
  endproperty
  a_syncQuarter: assert property (p_syncQuarter) else $error("sync edge misplaced");

  c_load:   cover property (loadActive);
  c_div8:   cover property (sampleTick && rfDivSel == RF_DIV8);
  c_full:   cover property (sampleTick && !fifoInReady);
  c_refDiv: cover property (refDivPulse && refPresc_reg != PRESC_RST);

endmodule

`default_nettype wire

/* File: design/dds_cos_lut.sv */
// Full-wave cosine lookup from phase to offset-binary amplitude.
`timescale 1ns/1ps
`default_nettype none

module dds_cos_lut #(
  parameter int PHASE_W = 10,
  parameter int AMP_W   = 10
) (
  // Phase in, amplitude out
  input  wire logic [PHASE_W-1:0] phase,
  output logic      [AMP_W-1:0]   amp
);

  localparam int  N      = 1 << PHASE_W;
  localparam real TWO_PI = 6.283185307179586;
  localparam real HALF   = (2.0 ** (AMP_W - 1)) - 0.5;

  logic [AMP_W-1:0] table_w [N];

  // The table is built at elaboration, so no memory image is needed.
  for (genvar i = 0; i < N; i++) begin : g_lut
    localparam int V = $rtoi(HALF + HALF * $cos(TWO_PI * real'(i) / real'(N)) + 0.5);
    assign table_w[i] = AMP_W'(V);
  end

  assign amp = table_w[phase];

endmodule

`default_nettype wire

/* File: design/dds_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module dds_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign inReady  = (count_reg != CNT_W'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end

endmodule

`default_nettype wire

/* File: design/dds_pkg.sv */
// Shared constants and types for the synthesizer core and its divider configuration.
package dds_pkg;

  // ---------------------------------------------------------------------------
  // Datapath widths
  // ---------------------------------------------------------------------------
  localparam int ACC_W      = 48;
  localparam int PHASE_W    = 14;
  localparam int LUT_W      = 10;
  localparam int DAC_W      = 10;
  localparam int PROFILES   = 8;
  localparam int PSEL_W     = 3;
  localparam int PRESC_W    = 4;
  localparam int PUMP_W     = 3;
  localparam int FIFO_DEPTH = 4;

  // ---------------------------------------------------------------------------
  // Divider and timing constants
  // ---------------------------------------------------------------------------
  localparam int         RFCNT_W     = 3;
  localparam int         SYNC_DIV    = 4;
  localparam logic [1:0] SYNC_LAST   = 2'h3;
  localparam int         SYNC_STAGES = 2;

  // ---------------------------------------------------------------------------
  // Configuration encodings and reset values
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {RF_DIV1, RF_DIV2, RF_DIV4, RF_DIV8} rfDiv_t;
  typedef enum logic [1:0] {DRV_UNDIV, DRV_DIV, DRV_FEEDBACK} drvSrc_t;

  localparam rfDiv_t               RF_DIV_RST    = RF_DIV1;
  localparam drvSrc_t              DRV_SRC_RST   = DRV_DIV;
  localparam logic [PRESC_W-1:0]   PRESC_RST     = 4'h0;
  localparam logic [PUMP_W-1:0]    PUMP_RST      = 3'h0;
  localparam logic [PUMP_W:0]      PUMP_ONE      = 4'h1;
  localparam logic [ACC_W-1:0]     TUNING_RST    = 48'h0;
  localparam logic [PHASE_W-1:0]   PHASE_RST     = 14'h0;

endpackage

/* File: tb/dac_sink.sv */
// Converter-side model that takes amplitude words and stalls on a fixed pattern.
`timescale 1ns/1ps
`default_nettype none

module dac_sink
  import dds_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Converter port
  input  wire logic             dacValid,
  input  wire logic [DAC_W-1:0] dacData,
  output logic                  dacReady,
  // Control and record
  input  wire logic             hold,
  output var int                count,
  output logic      [DAC_W-1:0] last,
  output logic      [DAC_W-1:0] prev
);
  logic [1:0] phaseCnt;

  initial begin
    phaseCnt = 2'h0;
    count = 0;
    last = '0;
    prev = '0;
  end

  // A real converter never refuses, but a stall every fourth cycle exercises the back-pressure path.
  assign dacReady = !hold && (phaseCnt != 2'h3);

  always @(posedge clk) begin
    phaseCnt <= phaseCnt + 2'h1;
    if (dacValid && dacReady) begin
      count <= count + 1;
      prev <= last;
      last <= dacData;
    end
  end
endmodule

`default_nettype wire

/* File: tb/dds_core_with_clock_dividers_tb.sv */
// Self-checking bench for the synthesizer core and its divider configuration.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin errorCnt++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end

module dds_core_with_clock_dividers_tb
  import dds_pkg::*;
;
  logic clk, nrst, masterReset, profWrEn, updateStrobe, referenceInput, feedbackInput, hold;
  logic [PSEL_W-1:0] profWrAddr, profileSelect;
  logic [ACC_W-1:0] profWrTuning;
  logic [PHASE_W-1:0] profWrPhase;
  rfDiv_t cfgRfDiv, rfDivSel;
  drvSrc_t cfgDrvSrc, drvSrc;
  logic [PRESC_W-1:0] cfgRefPresc, cfgFbPresc;
  logic [PUMP_W-1:0] cfgPumpScale, pumpScale;
  logic [PUMP_W:0] pumpMult;
  logic cfgSynthUndiv, cfgSurgeRise, cfgSurgeFall, cfgSurgeDefaultOff, cfgIntRes, cfgXtalOsc;
  logic dacValid, dacReady, syncOut, driverOut, refDivPulse, fbDivPulse, synthUndiv, syncPrev;
  logic surgeRiseEn, surgeFallEn, surgeDefaultOff, intResEn, xtalOscEn;
  logic [DAC_W-1:0] dacData, last, prev, held;
  int count, errorCnt, nCompared, refCnt, fbCnt, syncCnt;

  dds_core dut (.clk(clk), .nrst(nrst), .masterReset(masterReset), .profWrEn(profWrEn),
    .profWrAddr(profWrAddr), .profWrTuning(profWrTuning), .profWrPhase(profWrPhase), .cfgRfDiv(cfgRfDiv),
    .cfgSynthUndiv(cfgSynthUndiv), .cfgRefPresc(cfgRefPresc), .cfgFbPresc(cfgFbPresc),
    .cfgPumpScale(cfgPumpScale), .cfgDrvSrc(cfgDrvSrc), .cfgSurgeRise(cfgSurgeRise), .cfgSurgeFall(cfgSurgeFall),
    .cfgSurgeDefaultOff(cfgSurgeDefaultOff), .cfgIntRes(cfgIntRes), .cfgXtalOsc(cfgXtalOsc),
    .updateStrobe(updateStrobe), .profileSelect(profileSelect), .referenceInput(referenceInput),
    .feedbackInput(feedbackInput), .dacData(dacData), .dacValid(dacValid), .dacReady(dacReady),
    .syncOut(syncOut), .driverOut(driverOut), .refDivPulse(refDivPulse), .fbDivPulse(fbDivPulse),
    .rfDivSel(rfDivSel), .synthUndiv(synthUndiv), .pumpScale(pumpScale), .pumpMult(pumpMult), .drvSrc(drvSrc),
    .surgeRiseEn(surgeRiseEn), .surgeFallEn(surgeFallEn), .surgeDefaultOff(surgeDefaultOff),
    .intResEn(intResEn), .xtalOscEn(xtalOscEn));

  dac_sink sink (.clk(clk), .dacValid(dacValid), .dacData(dacData), .dacReady(dacReady), .hold(hold),
    .count(count), .last(last), .prev(prev));

  // The 100 MHz input stays under the sample-rate limit, so every divider setting is legal.
  always #5 clk = ~clk;

  // Outputs are registered, so the falling edge sees them settled.
  always @(negedge clk) begin
    if (refDivPulse === 1'b1) refCnt++;
    if (fbDivPulse === 1'b1) fbCnt++;
    if (syncOut === 1'b1 && syncPrev === 1'b0) syncCnt++;
    syncPrev = syncOut;
  end

  task automatic tally_and_finish();
    if (errorCnt == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_words(input int n);
    int target;
    target = count + n;
    for (int i = 0; i < 400 && count < target; i++) tick(1);
    if (count < target) begin
      `CHK("words", target, count)
      tally_and_finish();
    end
  endtask

  // Strobe spans more than one sync period at the slowest divider plus the pin synchroniser.
  task automatic load();
    updateStrobe = 1'b1;
    tick(40);
    updateStrobe = 1'b0;
    tick(4);
  endtask

  task automatic prof_wr(input logic [PSEL_W-1:0] a, input logic [ACC_W-1:0] t, input logic [PHASE_W-1:0] p);
    profWrEn = 1'b1;
    profWrAddr = a;
    profWrTuning = t;
    profWrPhase = p;
    tick(1);
    profWrEn = 1'b0;
    tick(1);
  endtask

  initial begin
    {clk, nrst, masterReset, profWrEn, updateStrobe, referenceInput, feedbackInput, hold, syncPrev} = '0;
    {profWrAddr, profileSelect, profWrTuning, profWrPhase, cfgRefPresc, cfgFbPresc} = '0;
    {cfgPumpScale, cfgSynthUndiv, cfgSurgeRise, cfgSurgeFall, cfgSurgeDefaultOff, cfgIntRes, cfgXtalOsc} = '0;
    cfgRfDiv = RF_DIV1;
    cfgDrvSrc = DRV_DIV;
    {errorCnt, nCompared, refCnt, fbCnt, syncCnt} = '0;
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    tick(3);
    `CHK("pumpMult", PUMP_ONE, pumpMult)
    `CHK("drvSrc", DRV_DIV, drvSrc)
    `CHK("rfDivSel", RF_DIV1, rfDivSel)
    {cfgPumpScale, cfgSurgeRise, cfgSurgeDefaultOff, cfgIntRes, cfgXtalOsc, cfgSynthUndiv} = {3'h7, 5'h1F};
    cfgRefPresc = 4'h2;
    cfgFbPresc = 4'hF;
    cfgDrvSrc = DRV_FEEDBACK;
    prof_wr(3'h0, 48'h0, 14'h0);
    prof_wr(3'h3, 48'h0, 14'h2000);
    prof_wr(3'h5, 48'h8000_0000_0000, 14'h0);
    load();
    `CHK("pumpMult", 4'h8, pumpMult)
    `CHK("drvSrc", DRV_FEEDBACK, drvSrc)
    `CHK("surge", 3'h5, {surgeRiseEn, surgeFallEn, surgeDefaultOff})
    `CHK("intResEn", 1'b1, intResEn)
    `CHK("xtalOscEn", 1'b1, xtalOscEn)
    `CHK("pumpScale", 3'h7, pumpScale)
    `CHK("synthUndiv", 1'b1, synthUndiv)
    wait_words(12);
    `CHK("ampZero", 10'h3FF, last)
    profileSelect = 3'h3;
    wait_words(12);
    `CHK("ampHalf", 10'h000, last)
    profileSelect = 3'h5;
    wait_words(12);
    `CHK("ampAlt", 10'h3FF, last ^ prev)
    hold = 1'b1;
    tick(20);
    held = dacData;
    tick(20);
    `CHK("stallHold", {1'b1, held}, {dacValid, dacData})
    hold = 1'b0;
    wait_words(8);
    repeat (48) begin
      {referenceInput, feedbackInput} = 2'h3;
      tick(2);
      {referenceInput, feedbackInput} = 2'h0;
      tick(2);
    end
    tick(8);
    `CHK("refPulses", 16, refCnt)
    `CHK("fbPulses", 3, fbCnt)
    feedbackInput = 1'b1;
    tick(6);
    `CHK("driverOut", 1'b1, driverOut)
    for (int k = 0; k < 5; k++) begin
      cfgRfDiv = rfDiv_t'((k == 4) ? 3 : k);
      cfgSynthUndiv = (k == 4);
      cfgDrvSrc = drvSrc_t'(k % 3);
      load();
      `CHK("drvSrc", drvSrc_t'(k % 3), drvSrc)
      `CHK("rfDivSel", cfgRfDiv, rfDivSel)
      `CHK("synthUndiv", cfgSynthUndiv, synthUndiv)
      syncCnt = 0;
      tick(64);
      `CHK("syncRises", (k == 4) ? 16 : (16 >> k), syncCnt)
    end
    masterReset = 1'b1;
    tick(4);
    `CHK("mrCfg", {PUMP_ONE, DRV_DIV, 1'b0}, {pumpMult, drvSrc, xtalOscEn})
    masterReset = 1'b0;
    tick(3);
    tally_and_finish();
  end
endmodule

`default_nettype wire
